// *** logic/pri_consts.svh ***
`ifndef PRI_CONSTS_SVH
`define PRI_CONSTS_SVH
`define PRI_REG_NUM_MAX      5'h1f
`define PRI_REG_IDENTITY     5'h00
`define PRI_ID_BYTE_MASK     16'h00ff
`define PRI_TERM_CONNECTED   3'h0
`define PRI_TERM_DISCONNECT  3'h7
`define PRI_CARD_MODULE_ID   5'h0f
`define PRI_WRITE_LIST_MAX   4'ha
`define PRI_CTL_CMD          4'h0
`define PRI_CTL_REGNUM       4'h1
`define PRI_CTL_DATA         4'h2
`define PRI_CTL_COUNT        4'h3
`define PRI_CTL_STATUS       4'h4
`define PRI_CTL_RDATA        4'h5
`define PRI_CTL_IDENT        4'h6
`define PRI_CMD_READ         2'h1
`define PRI_CMD_WRITE        2'h2
`define PRI_CMD_QUERY        2'h3
`define PRI_ST_BUSY          0
`define PRI_ST_INVALID       1
`define PRI_ST_PRESENT       2
`define PRI_ST_NEED_DATA     3
`endif

// *** logic/pri_pkg.sv ***
package pri_pkg;
    typedef logic [4:0]  pri_regnum_t;
    typedef logic [15:0] pri_word_t;
    typedef enum logic [1:0] {
        PRI_IDENT_EMPTY,
        PRI_IDENT_CONNECTED,
        PRI_IDENT_DISCONNECTED,
        PRI_IDENT_FOREIGN
    } pri_ident_t;
endpackage : pri_pkg

// *** logic/pri_bus_if.sv ***
`timescale 1ns/100ps
// backplane side: one-cycle strobes, read data one cycle after read strobe
interface pri_bus_if;
    import pri_pkg::*;
    logic        rd;
    logic        wr;
    pri_regnum_t regnum;
    pri_word_t   wdata;
    pri_word_t   rdata;
    logic        present;
    modport card (input rd, input wr, input regnum, input wdata, output rdata, output present);
    modport ctrl (output rd, output wr, output regnum, output wdata, input rdata, input present);
endinterface : pri_bus_if

// *** logic/pri_wreg.sv ***
`timescale 1ns/100ps
`include "pri_consts.svh"
// one 16-bit write register
module pri_wreg (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_wr,
    input  wire pri_pkg::pri_word_t i_data,
    output pri_pkg::pri_word_t    o_q
);
    import pri_pkg::*;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_q <= 16'h0000;
        end else if (i_wr) begin
            o_q <= i_data;
        end
    end
endmodule : pri_wreg

// *** logic/pri_card.sv ***
`timescale 1ns/100ps
`include "pri_consts.svh"
// card end: 32 write registers, read register 0 is identity,
// read registers 1..31 return write register contents
module pri_card (
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    pri_bus_if.card            bus,
    input  wire logic          i_term_connected,
    output pri_pkg::pri_word_t o_wreg [0:31]
);
    import pri_pkg::*;
    ////////////////////////////////////////////////////////////
    // write registers
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_wr
            wire logic sel;
            assign sel = bus.wr && (bus.regnum == 5'(g));
            pri_wreg u_reg (
                .i_clk   (i_clk),
                .i_rst_n (i_rst_n),
                .i_wr    (sel),
                .i_data  (bus.wdata),
                .o_q     (o_wreg[g])
            );
        end
    endgenerate
    ////////////////////////////////////////////////////////////
    // read side
    wire logic [2:0] term_field;
    wire pri_word_t  ident_word;
    wire pri_word_t  next_rdata;
    pri_word_t       rdata;
    assign term_field = i_term_connected ? `PRI_TERM_CONNECTED : `PRI_TERM_DISCONNECT;
    assign ident_word = {8'h00, `PRI_CARD_MODULE_ID, term_field};
    assign next_rdata = (bus.regnum == `PRI_REG_IDENTITY) ? ident_word : o_wreg[bus.regnum];
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata <= 16'h0000;
        end else if (bus.rd) begin
            rdata <= next_rdata;
        end
    end
    assign bus.rdata   = rdata;
    assign bus.present = 1'b1;
endmodule : pri_card

// *** logic/pri_ctrl.sv ***
// Strobed register access was decided locally.
`timescale 1ns/100ps
`include "pri_consts.svh"
// controller end: software orders via plain register port
module pri_ctrl (
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    input  wire logic [3:0]    i_addr,
    input  wire logic [15:0]   i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic      [15:0]   o_rdata,
    pri_bus_if.ctrl            bus
);
    import pri_pkg::*;
    typedef enum logic [2:0] {S_IDLE, S_RD, S_RD_WAIT, S_WR_WAIT, S_ID, S_ID_WAIT} pri_state_t;
    pri_state_t  state;
    logic [5:0]  regnum;       // six bits so out-of-range values are seen
    pri_word_t   data;
    logic        data_valid;
    logic [3:0]  left;
    logic        invalid;
    pri_word_t   rd_result;
    pri_ident_t  ident;
    logic [7:0]  ident_code;
    logic        boot;
    ////////////////////////////////////////////////////////////
    // decoding
    wire logic cmd_wr = i_wr && (i_addr == `PRI_CTL_CMD);
    wire logic idle   = (state == S_IDLE);
    wire logic bad_num = (regnum > {1'b0, `PRI_REG_NUM_MAX});
    wire logic data_wr = i_wr && (i_addr == `PRI_CTL_DATA);
    wire pri_word_t masked = bus.rdata & `PRI_ID_BYTE_MASK;
    ////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= S_IDLE; regnum <= 6'h00; data <= 16'h0000; data_valid <= 1'b0;
            left <= 4'h0; invalid <= 1'b0; rd_result <= 16'h0000;
            ident <= PRI_IDENT_EMPTY; ident_code <= 8'h00; boot <= 1'b1;
        end else begin
            if (i_wr && i_addr == `PRI_CTL_REGNUM && idle) regnum <= i_wdata[5:0];
            if (i_wr && i_addr == `PRI_CTL_COUNT && idle)
                left <= (i_wdata[3:0] > `PRI_WRITE_LIST_MAX) ? `PRI_WRITE_LIST_MAX : i_wdata[3:0];
            if (data_wr) begin
                data <= i_wdata;
                data_valid <= 1'b1;
            end
            case (state)
                S_IDLE: begin
                    if (boot) begin
                        boot <= 1'b0;
                        state <= S_ID;
                    end else if (cmd_wr) begin
                        invalid <= 1'b0;
                        if (i_wdata[1:0] == `PRI_CMD_QUERY) state <= S_ID;
                        else if (i_wdata[1:0] == `PRI_CMD_READ || i_wdata[1:0] == `PRI_CMD_WRITE) begin
                            if (bad_num || ident == PRI_IDENT_EMPTY || ident == PRI_IDENT_FOREIGN)
                                invalid <= 1'b1;
                            else if (i_wdata[1:0] == `PRI_CMD_READ) state <= S_RD;
                            else if (left != 4'h0) state <= S_WR_WAIT;
                        end
                    end
                end
                S_RD: state <= S_RD_WAIT;
                S_RD_WAIT: begin
                    rd_result <= bus.rdata;
                    state <= S_IDLE;
                end
                S_WR_WAIT: begin
                    if (data_valid && !data_wr) begin
                        data_valid <= 1'b0;
                        left <= left - 4'h1;
                        if (left == 4'h1) state <= S_IDLE;
                    end
                end
                S_ID: state <= S_ID_WAIT;
                S_ID_WAIT: begin
                    ident_code <= masked[7:0];
                    if (!bus.present) ident <= PRI_IDENT_EMPTY;
                    else if (masked[7:3] != `PRI_CARD_MODULE_ID) ident <= PRI_IDENT_FOREIGN;
                    else if (masked[2:0] == `PRI_TERM_CONNECTED) ident <= PRI_IDENT_CONNECTED;
                    else if (masked[2:0] == `PRI_TERM_DISCONNECT) ident <= PRI_IDENT_DISCONNECTED;
                    else ident <= PRI_IDENT_FOREIGN;
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
    ////////////////////////////////////////////////////////////
    // backplane drive; strobes are combinational: read from state, write from state, data_valid and data_wr
    // only five bits reach the card
    assign bus.regnum = (state == S_ID || state == S_ID_WAIT) ? `PRI_REG_IDENTITY : regnum[4:0];
    assign bus.rd     = (state == S_RD) || (state == S_ID);
    assign bus.wr     = (state == S_WR_WAIT) && data_valid && !data_wr;
    assign bus.wdata  = data;
    ////////////////////////////////////////////////////////////
    // software read port
    wire pri_word_t status = {12'h000, (state == S_WR_WAIT) && !data_valid,
                              ident == PRI_IDENT_CONNECTED || ident == PRI_IDENT_DISCONNECTED,
                              invalid, !idle || boot};
    wire pri_word_t next_rdata =
        (i_addr == `PRI_CTL_REGNUM) ? {10'h000, regnum} :
        (i_addr == `PRI_CTL_COUNT)  ? {12'h000, left} :
        (i_addr == `PRI_CTL_STATUS) ? status :
        (i_addr == `PRI_CTL_RDATA)  ? rd_result :
        (i_addr == `PRI_CTL_IDENT)  ? {6'h00, ident, ident_code} : 16'h0000;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) o_rdata <= 16'h0000;
        else o_rdata <= i_rd ? next_rdata : 16'h0000;
    end
endmodule : pri_ctrl

// *** test/pri_props.sv ***
`timescale 1ns/100ps
`include "pri_consts.svh"
module pri_props (
    input wire logic                i_clk,
    input wire logic                i_rst_n,
    input wire logic                rd,
    input wire logic                wr,
    input wire pri_pkg::pri_regnum_t regnum,
    input wire pri_pkg::pri_word_t  wdata,
    input wire pri_pkg::pri_word_t  rdata,
    input wire logic                present
);
    import pri_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////
    sequence s_id_rd; rd && regnum == `PRI_REG_IDENTITY; endsequence
    // reg 0 excluded: identity wins over the write register there
    sequence s_wr_rd; wr ##1 (rd && regnum == $past(regnum) && regnum != 5'h00); endsequence
    property p_excl; !(rd && wr); endproperty
    property p_modid; s_id_rd |=> rdata[7:3] == `PRI_CARD_MODULE_ID; endproperty
    property p_term; s_id_rd |=> rdata[2:0] inside {`PRI_TERM_CONNECTED, `PRI_TERM_DISCONNECT}; endproperty
    property p_readback; s_wr_rd |=> rdata == $past(wdata, 2); endproperty
    property p_hold; !rd |=> $stable(rdata); endproperty
    property p_present; present; endproperty
    property p_init; $rose(i_rst_n) |-> ##[0:4] s_id_rd; endproperty
    property p_quiet; $rose(i_rst_n) |-> !wr [*3]; endproperty
    a_excl: assert property (p_excl) else $error("read and write strobes together");
    a_modid: assert property (p_modid) else $error("identity module field wrong");
    a_term: assert property (p_term) else $error("identity terminal field wrong");
    a_readback: assert property (p_readback) else $error("written word not read back");
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    a_present: assert property (p_present) else $error("card not present");
    a_init: assert property (p_init) else $error("no identity read after reset");
    a_quiet: assert property (p_quiet) else $error("write right after reset");
endmodule : pri_props

// *** test/plugin_register_interface_tb.sv ***
`timescale 1ns/100ps
module plugin_register_interface_tb;
    import pri_pkg::*;
    logic        i_clk = 0, i_rst_n = 0, term = 1, i_wr = 0, i_rd = 0;
    logic [3:0]  i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0000, o_rdata, got;
    pri_word_t   wreg [0:31];
    int          err_count = 0, check_count = 0, r;
    int unsigned seed = 72967;
    int          mdl [0:31]; // model of the write registers
    pri_bus_if i_pri_bus_if ();
    pri_card i_pri_card (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(i_pri_bus_if), .i_term_connected(term), .o_wreg(wreg));
    pri_ctrl i_pri_ctrl (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .bus(i_pri_bus_if));
    pri_props i_pri_props (.i_clk(i_clk), .i_rst_n(i_rst_n), .rd(i_pri_bus_if.rd), .wr(i_pri_bus_if.wr),
        .regnum(i_pri_bus_if.regnum), .wdata(i_pri_bus_if.wdata), .rdata(i_pri_bus_if.rdata),
        .present(i_pri_bus_if.present));
    always #25 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////
    function automatic int unsigned rnd();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] act);
        check_count++;
        if (act !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, act);
        end
    endtask : chk
    task automatic bw(input logic [3:0] a, input logic [15:0] d);
        @(posedge i_clk) begin i_addr <= a; i_wdata <= d; i_wr <= 1'b1; end
        @(posedge i_clk) i_wr <= 1'b0;
    endtask : bw
    // read data stands only in the cycle after the strobe
    task automatic br(input logic [3:0] a, output logic [15:0] d);
        @(posedge i_clk) begin i_addr <= a; i_rd <= 1'b1; end
        @(posedge i_clk) i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : br
    // bounded poll on busy so a stuck controller cannot hang us
    task automatic idle();
        for (int k = 0; k < 40; k++) begin br(4'h4, got); if (got[0] === 1'b0) break; end
    endtask : idle
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////////
    initial begin #1000000; err_count++; results(); end
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst_n <= 1'b1;
        idle();
        br(4'h6, got); chk("ident", 16'h0178, got);
        for (int t = 0; t < 6; t++) begin
            r = (t == 0) ? 31 : 1 + rnd() % 31;
            bw(4'h3, 16'h0003); bw(4'h1, 16'(r)); bw(4'h0, 16'h0002);
            // a three-value list: the last value must win
            for (int v = 0; v < 3; v++) begin mdl[r] = rnd() & 16'hffff; bw(4'h2, 16'(mdl[r])); end
            idle(); chk("wreg", 16'(mdl[r]), wreg[r]);
            bw(4'h1, 16'(r)); bw(4'h0, 16'h0001); idle();
            br(4'h5, got); chk("rdata", 16'(mdl[r]), got);
        end
        bw(4'h1, 16'h0020); bw(4'h0, 16'h0001); idle();
        chk("invalid", 16'h0006, got & 16'h0006);
        term <= 1'b0; bw(4'h0, 16'h0003); idle();
        br(4'h6, got); chk("disc", 16'h027f, got);
        results();
    end
endmodule : plugin_register_interface_tb
